// ==== bench/idcp_core_properties.sv ====
// Checker of the bus timing and outputs of the code port.
`timescale 1ns/1ps
module idcp_core_properties (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       power_down_pin_i,
	input wire logic       power_down_control_o,
	input wire logic [9:0] dac_code_o,
	input wire logic       busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence start_seen; $fell(sda_i) && scl_i && $past(scl_i); endsequence
	sequence stop_seen; $rose(sda_i) && scl_i && $past(scl_i); endsequence
	chk_only_pull_low: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	chk_busy_on_start: assert property (start_seen |-> ##[1:6] busy_o)
		else $error("start not taken");
	chk_idle_on_stop: assert property (stop_seen ##0 !power_down_pin_i
		|-> ##[1:8] !busy_o)
		else $error("stop not taken");
	chk_idle_no_drive: assert property (!busy_o |-> !sda_oe_o)
		else $error("data pulled while idle");
	chk_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("pull began with clock high");
	chk_ack_width: assert property ($rose(sda_oe_o) |=> sda_oe_o [*4])
		else $error("pull too short");
	chk_steady_scl_high: assert property (scl_i && $past(scl_i)
		|-> $stable(sda_oe_o))
		else $error("data moved with clock high");
	chk_dac_hold_idle: assert property (!busy_o && !$past(busy_o)
		|-> $stable(dac_code_o))
		else $error("code moved while idle");
	chk_pin_forces_pd: assert property (power_down_pin_i
		|-> power_down_control_o)
		else $error("pin did not power down");
endmodule
bind idcp_core idcp_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.power_down_pin_i(power_down_pin_i), .dac_code_o(dac_code_o),
	.power_down_control_o(power_down_control_o), .busy_o(busy_o));

// ==== bench/idcp_master_model.sv ====
// Bus master model that makes the bus clock and pulls the data line.
`timescale 1ns/1ps
module idcp_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	// Data moves one cycle after the clock falls so the sync sees no race.
	task automatic bitx(input logic b, output logic r);
		scl_o = 1'b0;
		cyc(1);
		sda_oe_o = !b;
		cyc(3);
		scl_o = 1'b1;
		cyc(4);
		r = sda_i;
	endtask
	task automatic start();
		sda_oe_o = 1'b1;
		cyc(4);
	endtask
	task automatic xfer(input logic [7:0] w, input logic mack,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
		bitx(mack, ack);
	endtask
	task automatic stop();
		scl_o = 1'b0;
		cyc(1);
		sda_oe_o = 1'b1;
		cyc(3);
		scl_o = 1'b1;
		cyc(4);
		sda_oe_o = 1'b0;
		cyc(4);
	endtask
endmodule

// ==== bench/tb_idcp_core.sv ====
// Self-checking bench of the code port driven through a bus master model.
`timescale 1ns/1ps
module tb_idcp_core;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        down_pin = 1'b0;
	logic        scl, m_oe, sda_o, s_oe, pdc, busy;
	logic [9:0]  code;
	logic [15:0] words [4] = '{16'h7FFF, 16'h8000, 16'h5A5A, 16'hA5A5};
	wire         sda = !(m_oe || s_oe);
	int          n_errors = 0;
	int          checks = 0;
	always #10 clk_i = !clk_i;
	idcp_core uut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(s_oe), .power_down_pin_i(down_pin),
		.power_down_control_o(pdc), .dac_code_o(code), .busy_o(busy));
	idcp_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
		.sda_oe_o(m_oe));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Reads send all ones so the master releases the line except to ack the high byte.
	task automatic xact(input logic [7:0] a, input logic [15:0] w,
		output logic [15:0] r, output logic [2:0] ak);
		logic [7:0] ra;
		m.start();
		m.xfer(a, 1'b1, ra, ak[2]);
		m.xfer(w[15:8], !a[0], r[15:8], ak[1]);
		m.xfer(w[7:0], 1'b1, r[7:0], ak[0]);
		m.stop();
		for (int i = 0; i < 20 && busy !== 1'b0; i++) m.cyc(1);
		if (busy !== 1'b0) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	initial begin
		logic [15:0] r;
		logic [2:0]  ak;
		repeat (6) @(posedge clk_i);
		#2 rst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#2 chk({5'h00, pdc, code}, 16'h0000);
		chk({15'h0000, s_oe}, 16'h0000);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			xact(8'(8'h18 + 2 * k), words[k], r, ak);
			chk({13'h0000, ak}, 16'h0000);
			chk({15'h0000, pdc}, {15'h0000, words[k][15]});
			chk({6'h00, code}, {6'h00, words[k][13:4]});
			xact(8'(8'h19 + 2 * k), 16'hFFFF, r, ak);
			chk(r, words[k]);
			chk({15'h0000, ak[2]}, 16'h0000);
			xact(8'(8'h19 + 2 * k), 16'hFFFF, r, ak);
			chk(r, 16'h0000);
			chk({6'h00, code}, {6'h00, words[k][13:4]});
		end
		$display("test write read done");
		xact(8'h10, 16'h0000, r, ak);
		chk({13'h0000, ak}, 16'h0007);
		chk({6'h00, code}, {6'h00, words[3][13:4]});
		$display("test mismatch done");
		xact(8'h1E, 16'h0000, r, ak);
		chk({13'h0000, ak}, 16'h0000);
		@(posedge clk_i);
		#2 down_pin = 1'b1;
		#1 chk({15'h0000, pdc}, 16'h0001);
		@(posedge clk_i);
		#2 down_pin = 1'b0;
		#1 chk({15'h0000, pdc}, 16'h0000);
		$display("test power down done");
		report_and_stop();
	end
endmodule

// ==== design/idcp_core.sv ====
// Two-wire slave port that loads and reads back the converter input word.
`timescale 1ns/1ps
`include "idcp_defines.svh"

// Functional notes
// - A start (SDA falls, SCL high) begins a transfer; eight bits follow.
// - First byte is seven address bits then direction, 0 write 1 read.
// - Address 0001100 with two low address bits ignored selects the port.
// - On match, pull SDA low while SCL low, hold through ninth pulse.
// - Acknowledge every eight-bit block received after an address match; bytes after the second data byte get no ack.
// - Exactly two data bytes per transfer; second write byte acknowledged.
// - A stop (SDA rises, SCL high) ends the transfer.
// - Data enters the 16-bit input word high byte first, MSB first.
// - After both bytes arrive, input word is copied to the converter.
// - Input word bit 15 is active-high soft power-down.
// - Bits 13..4 are the ten-bit code; bit 14 and 3..0 unused.
// - Reads return the input word high byte first, MSB first.
// - After a read completes the input word clears to zero.
// - Bus clock up to 400 kHz is supported for writes and reads.
// - Lines are only pulled low or released; idle bus reads high.
// - A power-down pin forces power-down without any bus clock.
module idcp_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        power_down_pin_i,
	output logic             power_down_control_o,
	output logic [9:0]       dac_code_o,
	output logic             busy_o
);
	import idcp_pkg::*;

	// The sampler sees each bus phase at least this many clocks.
	localparam int unsigned PHASE_CLKS =
		`IDCP_CLK_HZ / (2 * `IDCP_BUS_MAX_HZ);

	idcp_pins_if ev ();

	idcp_pin_sampler u_sampler (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.scl_i (scl_i),
		.sda_i (sda_i),
		.ev    (ev)
	);

	idcp_state_t  state_q,   state_d;
	logic [3:0]   bit_cnt_q, bit_cnt_d;
	logic [7:0]   shift_q,   shift_d;
	logic [15:0]  word_q,    word_d;
	logic [15:0]  dac_q,     dac_d;
	logic         rd_q,      rd_d;
	logic         byte_q,    byte_d;
	logic         drive_q,   drive_d;
	logic [7:0]   tx_q,      tx_d;
	logic         data_q,    data_d;
	logic         down_pin_s0_q, down_pin_q;
	logic         down_pin_s0_d, down_pin_d;

	function automatic logic addr_hit(input logic [7:0] b);
		addr_hit = (b[7:3] == `IDCP_ADDR_UPPER);
	endfunction

	always_comb begin
		state_d   = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d   = shift_q;
		word_d    = word_q;
		dac_d     = dac_q;
		rd_d      = rd_q;
		byte_d    = byte_q;
		drive_d   = drive_q;
		tx_d      = tx_q;
		data_d    = data_q;
		if (ev.start_ev) begin
			state_d   = IDCP_ADDR;
			bit_cnt_d = 4'h0;
			drive_d   = 1'b0;
			byte_d    = 1'b0;
			data_d    = 1'b0;
		end else if (ev.stop_ev) begin
			state_d = IDCP_IDLE;
			drive_d = 1'b0;
		end else begin
			case (state_q)
			IDCP_IDLE: begin
				drive_d = 1'b0;
			end
			IDCP_ADDR, IDCP_WR: begin
				if (ev.scl_rise) begin
					shift_d   = {shift_q[6:0], ev.sda_lvl};
					bit_cnt_d = bit_cnt_q + 4'h1;
				end
				if (ev.scl_fall && bit_cnt_q == `IDCP_BITS_PER_BYTE) begin
					bit_cnt_d = 4'h0;
					if (state_q == IDCP_ADDR) begin
						if (addr_hit(shift_q)) begin
							rd_d    = shift_q[0];
							drive_d = 1'b1;
							state_d = IDCP_ACK;
						end else begin
							state_d = IDCP_IDLE;
						end
					end else begin
						drive_d = 1'b1;
						state_d = IDCP_ACK;
						if (byte_q) begin
							word_d[7:0] = shift_q;
							dac_d = {word_q[15:8], shift_q};
						end else begin
							word_d[15:8] = shift_q;
						end
					end
				end
			end
			IDCP_ACK: begin
				// The pull ends with the fall that closes the ninth pulse.
				if (ev.scl_fall) begin
					drive_d = 1'b0;
					data_d  = 1'b1;
					if (rd_q) begin
						tx_d    = word_q[15:8];
						drive_d = ~word_q[15];
						state_d = IDCP_RD;
					end else if (data_q && byte_q) begin
						// Bytes after the second are left unanswered.
						state_d = IDCP_IDLE;
					end else begin
						// The address ack must not count as a data byte.
						byte_d  = data_q;
						state_d = IDCP_WR;
					end
				end
			end
			IDCP_RD: begin
				if (ev.scl_fall) begin
					bit_cnt_d = bit_cnt_q + 4'h1;
					tx_d      = {tx_q[6:0], 1'b0};
					drive_d   = ~tx_q[6];
					if (bit_cnt_q == 4'h7) begin
						drive_d   = 1'b0;
						bit_cnt_d = 4'h0;
						state_d   = IDCP_RACK;
					end
				end
			end
			IDCP_RACK: begin
				// Master answers here; a read ends after the second byte.
				if (ev.scl_fall) begin
					if (byte_q) begin
						word_d  = `IDCP_WORD_RESET;
						state_d = IDCP_IDLE;
					end else begin
						byte_d  = 1'b1;
						tx_d    = word_q[7:0];
						drive_d = ~word_q[7];
						state_d = IDCP_RD;
					end
				end
			end
			default: begin
				state_d = IDCP_IDLE;
				drive_d = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= IDCP_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
			word_q    <= `IDCP_WORD_RESET;
			dac_q     <= `IDCP_WORD_RESET;
			rd_q      <= 1'b0;
			byte_q    <= 1'b0;
			drive_q   <= 1'b0;
			tx_q      <= 8'h00;
			data_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q   <= shift_d;
			word_q    <= word_d;
			dac_q     <= dac_d;
			rd_q      <= rd_d;
			byte_q    <= byte_d;
			drive_q   <= drive_d;
			tx_q      <= tx_d;
			data_q    <= data_d;
		end
	end

	// The pin is synchronised for the status view only; the forcing path
	// below is combinational so it acts with no clock at all.
	always_comb begin
		down_pin_s0_d = power_down_pin_i;
		down_pin_d    = down_pin_s0_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			down_pin_s0_q <= 1'b0;
			down_pin_q    <= 1'b0;
		end else begin
			down_pin_s0_q <= down_pin_s0_d;
			down_pin_q    <= down_pin_d;
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = drive_q;
	assign power_down_control_o = dac_q[`IDCP_POWER_DOWN_BIT]
		| power_down_pin_i;
	assign dac_code_o = dac_q[`IDCP_CODE_MSB:`IDCP_CODE_LSB];
	assign busy_o     = (state_q != IDCP_IDLE) | down_pin_q
		| (PHASE_CLKS == 0);
endmodule

// ==== design/idcp_defines.svh ====
// Constants for the two-wire code port of the current-sink converter.
`ifndef IDCP_DEFINES_SVH
`define IDCP_DEFINES_SVH
`define IDCP_ADDR_UPPER   5'h03
`define IDCP_WORD_RESET   16'h0000
`define IDCP_POWER_DOWN_BIT 15
`define IDCP_CODE_MSB     13
`define IDCP_CODE_LSB     4
`define IDCP_CLK_HZ       50000000
`define IDCP_BUS_MAX_HZ   400000
`define IDCP_BITS_PER_BYTE 4'h8
`endif

// ==== design/idcp_pin_sampler.sv ====
// Synchronises the bus pins and reports clock edges, start and stop.
`timescale 1ns/1ps
module idcp_pin_sampler (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	idcp_pins_if.sampler ev
);
	logic [1:0] scl_sync_q, scl_sync_d;
	logic [1:0] sda_sync_q, sda_sync_d;
	logic       scl_old_q,  scl_old_d;
	logic       sda_old_q,  sda_old_d;

	always_comb begin
		scl_sync_d = {scl_sync_q[0], scl_i};
		sda_sync_d = {sda_sync_q[0], sda_i};
		scl_old_d  = scl_sync_q[1];
		sda_old_d  = sda_sync_q[1];
	end

	// Idle lines read high, so reset to high to avoid a false start.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_old_q  <= 1'b1;
			sda_old_q  <= 1'b1;
		end else begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_old_q  <= scl_old_d;
			sda_old_q  <= sda_old_d;
		end
	end

	assign ev.scl_rise = scl_sync_q[1] & ~scl_old_q;
	assign ev.scl_fall = ~scl_sync_q[1] & scl_old_q;
	assign ev.sda_lvl  = sda_sync_q[1];
	assign ev.start_ev = scl_sync_q[1] & scl_old_q & sda_old_q
		& ~sda_sync_q[1];
	assign ev.stop_ev  = scl_sync_q[1] & scl_old_q & ~sda_old_q
		& sda_sync_q[1];
endmodule

// ==== design/idcp_pins_if.sv ====
// Conditioned bus events passed from the pin sampler to the protocol core.
`timescale 1ns/1ps
interface idcp_pins_if;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic start_ev;
	logic stop_ev;
	modport sampler (output scl_rise, scl_fall, sda_lvl, start_ev, stop_ev);
	modport core    (input  scl_rise, scl_fall, sda_lvl, start_ev, stop_ev);
endinterface

// ==== design/idcp_pkg.sv ====
// Types shared by the code port modules.
package idcp_pkg;
	typedef enum logic [5:0] {
		IDCP_IDLE = 6'h01,
		IDCP_ADDR = 6'h02,
		IDCP_ACK  = 6'h04,
		IDCP_WR   = 6'h08,
		IDCP_RD   = 6'h10,
		IDCP_RACK = 6'h20
	} idcp_state_t;
endpackage
